// [pkg/ssw_pkg.sv]
// constants and carrier types of the supply supervisor and window watchdog
// Function
// - either enable input turns on or holds regulators while battery is valid
// - regulators go off only when both enable inputs are inactive or battery is not valid
// - stand-by regulator enable ignores both enable inputs
// - over-temperature disables buck until the cool-down indication returns
// - primary reset pulls low while the 5 V rail is out of range
// - secondary reset pulls low while mid or external rail is out of range
// - each reset releases 160 ticks after its rails return in range
// - with primary reset high, monitor low exactly during stand-by undervoltage
// - undervoltage during primary reset holds monitor low until delay after release
// - watchdog off after reset, started by trigger held low after release
// - trigger high before start hold time leaves watchdog inactive
// - watchdog switches off whenever secondary reset goes low
// - started watchdog ignores the trigger for the ignore window
// - open window ends at timeout or at once on a valid trigger
// - closed window lasts one window time, then open window again
// - valid trigger needs two high samples then two low samples
// - trigger whose last low sample lands in open window is no fault
// - missing or closed-window trigger pulls fault output low one window
// - stopped time base keeps closed window, so every second trigger faults
// - all supply enables except stand-by drop immediately when both inputs are inactive
package ssw_pkg;
    localparam int CLK_PERIOD_NS = 5;
    localparam int TICK_NS_PER_NF = 50000;
    localparam int DELAY_CAP_PF = 1000;
    localparam int TICK_CYCLES_DFLT =
        TICK_NS_PER_NF / CLK_PERIOD_NS * DELAY_CAP_PF / 1000;
    localparam int SAMPLE_PERIOD_NS = 1000;
    localparam int SAMPLE_CYCLES =
        (SAMPLE_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [15:0] RESET_DELAY_TICKS = 16'h00A0;
    localparam logic [15:0] INIT_HOLD_TICKS = 16'h0004;
    localparam logic [15:0] IGNORE_TICKS = 16'h0040;
    localparam logic [15:0] WINDOW_TICKS = 16'h0020;
    localparam logic [15:0] MON_DELAY_TICKS = 16'h0008;
    localparam logic [3:0] TRIG_PATTERN = 4'hC;

    // comparator results, one bit each, high means condition present
    typedef struct packed {
        logic battery_ok;
        logic ot_shutdown;
        logic ot_cooled;
        logic rail_5v_ok;
        logic rail_mid_ok;
        logic ext_fb_ok;
        logic standby_uv;
    } ssw_status_type;

    // enables towards the analog supply blocks
    typedef struct packed {
        logic charge_pump;
        logic buck;
        logic regulators;
        logic trackers;
        logic standby;
    } ssw_supply_en_type;

    typedef enum logic [4:0] {
        WD_OFF = 5'h01,
        WD_HOLD = 5'h02,
        WD_IGNORE = 5'h04,
        WD_OPEN = 5'h08,
        WD_CLOSED = 5'h10
    } ssw_wd_state_type;
endpackage : ssw_pkg

// [design/ssw_sync.sv]
// two-stage synchroniser for a bundle of comparator levels
`timescale 1ns/10ps
module ssw_sync #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_ff;

    // first stage feeds only the second stage
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            meta_ff <= '0;
            q <= '0;
        end
        else
        begin
            meta_ff <= d;
            q <= meta_ff;
        end
    end
endmodule : ssw_sync

// [design/ssw_rst_gen.sv]
// reset generator with release delay counted in time-base ticks
`timescale 1ns/10ps
module ssw_rst_gen
    import ssw_pkg::*;
(
    input wire logic clk,
    input wire logic srst,
    input wire logic rail_ok,
    input wire logic tick,
    output logic released
);
    logic [15:0] cnt_ff;

    // any excursion drops reset at once; release waits the full delay
    always_ff @(posedge clk)
    begin
        if (srst || !rail_ok)
        begin
            cnt_ff <= 16'h0000;
            released <= 1'b0;
        end
        else if (tick && !released)
        begin
            if (cnt_ff == RESET_DELAY_TICKS - 16'h0001)
                released <= 1'b1;
            cnt_ff <= cnt_ff + 16'h0001;
        end
    end

    rel_delay_a: assert property (@(posedge clk) disable iff (srst)
        $rose(released) |-> cnt_ff == RESET_DELAY_TICKS)
        else $error("reset released before its delay");
endmodule : ssw_rst_gen

// [design/ssw_top.sv]
// supervisor top: enables, resets, stand-by monitor, window watchdog
`timescale 1ns/10ps
module ssw_top
    import ssw_pkg::*;
#(
    parameter int TICK_CYCLES = ssw_pkg::TICK_CYCLES_DFLT
) (
    input wire logic REF_CLK,
    input wire logic SRST,
    input wire logic IGNITION_ENABLE_IN,
    input wire logic CONTROLLER_ENABLE_IN,
    input wire ssw_pkg::ssw_status_type RAIL_STATUS,
    input wire logic TIMEBASE_STOP,
    input wire logic WD_TRIGGER_IN,
    input wire logic RESET_OUT_PRIMARY_IN,
    input wire logic RESET_OUT_SECONDARY_IN,
    output ssw_pkg::ssw_supply_en_type SUPPLY_EN,
    output logic RESET_OUT_PRIMARY_DRV,
    output logic RESET_OUT_PRIMARY_OE,
    output logic RESET_OUT_SECONDARY_DRV,
    output logic RESET_OUT_SECONDARY_OE,
    output logic STANDBY_MONITOR_OUT,
    output logic WD_FAULT_OUT,
    output logic WD_ACTIVE
);
    import ssw_pkg::*;

    // ----------------------------------------
    // declarations
    // ----------------------------------------
    ssw_status_type sts;
    logic [31:0] tick_cnt_ff;
    logic [31:0] smp_cnt_ff;
    logic tick_ff;
    logic smp_ff;
    logic en_any;
    logic ot_ff;
    logic rst1_rel;
    logic rst2_rel;
    logic rst1_hi;
    logic rst2_hi;
    logic rst2_hi_q_ff;
    logic mon_lat_ff;
    logic nxt_mon_lat;
    logic [15:0] mon_cnt_ff;
    logic [3:0] hist_ff;
    logic trig_ok;
    ssw_wd_state_type state_ff;
    ssw_wd_state_type nxt_state;
    logic [15:0] win_cnt_ff;
    logic [15:0] nxt_win_cnt;
    logic fault_evt;
    logic [15:0] flt_cnt_ff;

    // ----------------------------------------
    // comparator synchronisation and time base
    // ----------------------------------------
    // comparators are asynchronous analog results
    ssw_sync #(
        .W($bits(ssw_status_type))
    ) u_sync (
        .clk(REF_CLK),
        .srst(SRST),
        .d(RAIL_STATUS),
        .q(sts)
    );

    // tick of the capacitor oscillator; a stop freezes all windows
    always_ff @(posedge REF_CLK)
    begin
        if (SRST)
        begin
            tick_cnt_ff <= 32'h0000_0000;
            tick_ff <= 1'b0;
        end
        else if (TIMEBASE_STOP)
        begin
            tick_ff <= 1'b0;
        end
        else if (tick_cnt_ff == 32'(TICK_CYCLES - 1))
        begin
            tick_cnt_ff <= 32'h0000_0000;
            tick_ff <= 1'b1;
        end
        else
        begin
            tick_cnt_ff <= tick_cnt_ff + 32'h0000_0001;
            tick_ff <= 1'b0;
        end
    end

    // trigger sampling keeps running without the oscillator,
    // otherwise a dead time base could never be reported
    always_ff @(posedge REF_CLK)
    begin
        if (SRST || smp_cnt_ff == 32'(SAMPLE_CYCLES - 1))
            smp_cnt_ff <= 32'h0000_0000;
        else
            smp_cnt_ff <= smp_cnt_ff + 32'h0000_0001;
    end

    always_ff @(posedge REF_CLK)
    begin
        if (SRST)
            smp_ff <= 1'b0;
        else
            smp_ff <= (smp_cnt_ff == 32'(SAMPLE_CYCLES - 1));
    end

    // ----------------------------------------
    // device enable and thermal shutdown
    // ----------------------------------------
    assign en_any = IGNITION_ENABLE_IN | CONTROLLER_ENABLE_IN;

    // latch holds off buck until the cooled comparator confirms
    always_ff @(posedge REF_CLK)
    begin
        if (SRST)
            ot_ff <= 1'b0;
        else if (sts.ot_shutdown)
            ot_ff <= 1'b1;
        else if (sts.ot_cooled)
            ot_ff <= 1'b0;
    end

    // all main enables fall in one cycle, no sequencing
    always_ff @(posedge REF_CLK)
    begin
        if (SRST)
        begin
            SUPPLY_EN <= '0;
        end
        else
        begin
            SUPPLY_EN.charge_pump <= en_any & sts.battery_ok;
            SUPPLY_EN.buck <= en_any & sts.battery_ok
                & ~ot_ff & ~sts.ot_shutdown;
            SUPPLY_EN.regulators <= en_any & sts.battery_ok;
            SUPPLY_EN.trackers <= en_any & sts.battery_ok;
            SUPPLY_EN.standby <= sts.battery_ok;
        end
    end

    // ----------------------------------------
    // reset outputs
    // ----------------------------------------
    ssw_rst_gen u_rst1 (
        .clk(REF_CLK),
        .srst(SRST),
        .rail_ok(sts.rail_5v_ok),
        .tick(tick_ff),
        .released(rst1_rel)
    );

    ssw_rst_gen u_rst2 (
        .clk(REF_CLK),
        .srst(SRST),
        .rail_ok(sts.rail_mid_ok & sts.ext_fb_ok),
        .tick(tick_ff),
        .released(rst2_rel)
    );

    // open drain: drive value is always low, enable pulls the line
    always_ff @(posedge REF_CLK)
    begin
        if (SRST)
        begin
            RESET_OUT_PRIMARY_DRV <= 1'b0;
            RESET_OUT_PRIMARY_OE <= 1'b1;
            RESET_OUT_SECONDARY_DRV <= 1'b0;
            RESET_OUT_SECONDARY_OE <= 1'b1;
        end
        else
        begin
            RESET_OUT_PRIMARY_DRV <= 1'b0;
            RESET_OUT_PRIMARY_OE <= ~rst1_rel;
            RESET_OUT_SECONDARY_DRV <= 1'b0;
            RESET_OUT_SECONDARY_OE <= ~rst2_rel;
        end
    end

    // wire level counts, so another party holding a reset is seen too
    assign rst1_hi = RESET_OUT_PRIMARY_IN & ~RESET_OUT_PRIMARY_OE;
    assign rst2_hi = RESET_OUT_SECONDARY_IN & ~RESET_OUT_SECONDARY_OE;

    // ----------------------------------------
    // stand-by monitor
    // ----------------------------------------
    // latch remembers an undervoltage seen while primary reset was low
    always_comb
    begin
        nxt_mon_lat = mon_lat_ff;
        if (sts.standby_uv && !rst1_hi)
            nxt_mon_lat = 1'b1;
        else if (mon_lat_ff && rst1_hi && tick_ff
            && mon_cnt_ff == MON_DELAY_TICKS - 16'h0001)
            nxt_mon_lat = 1'b0;
    end

    always_ff @(posedge REF_CLK)
    begin
        if (SRST)
        begin
            mon_lat_ff <= 1'b0;
            mon_cnt_ff <= 16'h0000;
            STANDBY_MONITOR_OUT <= 1'b1;
        end
        else
        begin
            mon_lat_ff <= nxt_mon_lat;
            if (!mon_lat_ff || !rst1_hi)
                mon_cnt_ff <= 16'h0000;
            else if (tick_ff)
                mon_cnt_ff <= mon_cnt_ff + 16'h0001;
            STANDBY_MONITOR_OUT <= ~sts.standby_uv & ~nxt_mon_lat;
        end
    end

    // ----------------------------------------
    // trigger qualification
    // ----------------------------------------
    // oldest sample in the top bit; high high low low is one edge
    assign trig_ok = smp_ff
        && {hist_ff[2:0], WD_TRIGGER_IN} == TRIG_PATTERN;

    always_ff @(posedge REF_CLK)
    begin
        if (SRST)
            hist_ff <= 4'h0;
        else if (smp_ff)
            hist_ff <= {hist_ff[2:0], WD_TRIGGER_IN};
    end

    always_ff @(posedge REF_CLK)
    begin
        if (SRST)
            rst2_hi_q_ff <= 1'b0;
        else
            rst2_hi_q_ff <= rst2_hi;
    end

    // ----------------------------------------
    // window watchdog sequencer
    // ----------------------------------------
    // a trigger in the closed window restarts an open window, so a
    // frozen closed window faults on every second trigger
    always_comb
    begin
        nxt_state = state_ff;
        nxt_win_cnt = win_cnt_ff;
        fault_evt = 1'b0;
        case (state_ff)
            WD_OFF:
            begin
                if (rst2_hi && !rst2_hi_q_ff)
                begin
                    nxt_state = WD_HOLD;
                    nxt_win_cnt = 16'h0000;
                end
            end
            WD_HOLD:
            begin
                if (WD_TRIGGER_IN)
                    nxt_state = WD_OFF;
                else if (tick_ff)
                begin
                    nxt_win_cnt = win_cnt_ff + 16'h0001;
                    if (win_cnt_ff == INIT_HOLD_TICKS - 16'h0001)
                    begin
                        nxt_state = WD_IGNORE;
                        nxt_win_cnt = 16'h0000;
                    end
                end
            end
            WD_IGNORE:
            begin
                if (tick_ff)
                begin
                    nxt_win_cnt = win_cnt_ff + 16'h0001;
                    if (win_cnt_ff == IGNORE_TICKS - 16'h0001)
                    begin
                        nxt_state = WD_OPEN;
                        nxt_win_cnt = 16'h0000;
                    end
                end
            end
            WD_OPEN:
            begin
                if (trig_ok)
                begin
                    nxt_state = WD_CLOSED;
                    nxt_win_cnt = 16'h0000;
                end
                else if (tick_ff)
                begin
                    nxt_win_cnt = win_cnt_ff + 16'h0001;
                    if (win_cnt_ff == WINDOW_TICKS - 16'h0001)
                    begin
                        fault_evt = 1'b1;
                        nxt_win_cnt = 16'h0000;
                    end
                end
            end
            WD_CLOSED:
            begin
                if (trig_ok)
                begin
                    fault_evt = 1'b1;
                    nxt_state = WD_OPEN;
                    nxt_win_cnt = 16'h0000;
                end
                else if (tick_ff)
                begin
                    nxt_win_cnt = win_cnt_ff + 16'h0001;
                    if (win_cnt_ff == WINDOW_TICKS - 16'h0001)
                    begin
                        nxt_state = WD_OPEN;
                        nxt_win_cnt = 16'h0000;
                    end
                end
            end
            default:
            begin
                nxt_state = WD_OFF;
                nxt_win_cnt = 16'h0000;
            end
        endcase
        if (!rst2_hi)
        begin
            nxt_state = WD_OFF;
            fault_evt = 1'b0;
        end
    end

    always_ff @(posedge REF_CLK)
    begin
        if (SRST)
        begin
            state_ff <= WD_OFF;
            win_cnt_ff <= 16'h0000;
            WD_ACTIVE <= 1'b0;
        end
        else
        begin
            state_ff <= nxt_state;
            win_cnt_ff <= nxt_win_cnt;
            WD_ACTIVE <= (nxt_state == WD_IGNORE)
                || (nxt_state == WD_OPEN) || (nxt_state == WD_CLOSED);
        end
    end

    // ----------------------------------------
    // fault output
    // ----------------------------------------
    // low for one window time after each fault, a new fault restarts it
    always_ff @(posedge REF_CLK)
    begin
        if (SRST)
        begin
            flt_cnt_ff <= 16'h0000;
            WD_FAULT_OUT <= 1'b1;
        end
        else if (fault_evt)
        begin
            flt_cnt_ff <= WINDOW_TICKS;
            WD_FAULT_OUT <= 1'b0;
        end
        else if (tick_ff && flt_cnt_ff != 16'h0000)
        begin
            flt_cnt_ff <= flt_cnt_ff - 16'h0001;
            if (flt_cnt_ff == 16'h0001)
                WD_FAULT_OUT <= 1'b1;
        end
    end

    // ----------------------------------------
    // checks
    // ----------------------------------------
    en_or_a: assert property (@(posedge REF_CLK) disable iff (SRST)
        (en_any && sts.battery_ok) |=> SUPPLY_EN.regulators)
        else $error("regulators not enabled by an enable input");

    all_off_a: assert property (@(posedge REF_CLK) disable iff (SRST)
        !IGNITION_ENABLE_IN && !CONTROLLER_ENABLE_IN
        |=> !SUPPLY_EN.charge_pump && !SUPPLY_EN.buck
        && !SUPPLY_EN.regulators && !SUPPLY_EN.trackers)
        else $error("supply enables kept with both inputs inactive");

    stby_en_a: assert property (@(posedge REF_CLK) disable iff (SRST)
        $past(sts.battery_ok) == SUPPLY_EN.standby)
        else $error("stand-by enable follows something else");

    ot_buck_a: assert property (@(posedge REF_CLK) disable iff (SRST)
        sts.ot_shutdown ##1 !sts.ot_cooled |=> !SUPPLY_EN.buck)
        else $error("buck enabled before cooling");

    rst_pull_a: assert property (@(posedge REF_CLK) disable iff (SRST)
        !sts.rail_5v_ok |=> ##1 RESET_OUT_PRIMARY_OE)
        else $error("primary reset not pulled on bad 5V rail");

    rst2_pull_a: assert property (@(posedge REF_CLK) disable iff (SRST)
        !sts.ext_fb_ok || !sts.rail_mid_ok |=> ##1 RESET_OUT_SECONDARY_OE)
        else $error("secondary reset not pulled on bad rail");

    mon_fail_a: assert property (@(posedge REF_CLK) disable iff (SRST)
        sts.standby_uv |=> !STANDBY_MONITOR_OUT)
        else $error("monitor high during stand-by undervoltage");

    mon_hold_a: assert property (@(posedge REF_CLK) disable iff (SRST)
        mon_lat_ff && !rst1_hi |=> !STANDBY_MONITOR_OUT)
        else $error("monitor released while primary reset low");

    wd_off_a: assert property (@(posedge REF_CLK) disable iff (SRST)
        !rst2_hi |=> state_ff == WD_OFF && !WD_ACTIVE)
        else $error("watchdog running with secondary reset low");

    ign_trig_a: assert property (@(posedge REF_CLK) disable iff (SRST)
        state_ff == WD_IGNORE && rst2_hi && WD_FAULT_OUT
        |=> state_ff != WD_CLOSED && WD_FAULT_OUT)
        else $error("trigger acted on during ignore window");

    open_trig_a: assert property (@(posedge REF_CLK) disable iff (SRST)
        state_ff == WD_OPEN && trig_ok && rst2_hi
        |=> state_ff == WD_CLOSED && win_cnt_ff == 16'h0000)
        else $error("valid trigger did not close the window");

    fault_low_a: assert property (@(posedge REF_CLK) disable iff (SRST)
        fault_evt |=> !WD_FAULT_OUT && flt_cnt_ff == WINDOW_TICKS)
        else $error("fault did not pull the output low");
endmodule : ssw_top

// [dv/ssw_mcu_model.sv]
// microcontroller model that drives the watchdog trigger pin
`timescale 1ns/10ps
module ssw_mcu_model (
    input wire logic clk,
    input wire logic srst,
    input wire logic [1:0] mode,
    input wire logic rst_n,
    output logic wd_trig
);
    import ssw_pkg::*;

    logic [10:0] cnt_ff;
    logic [1:0] mode_ff;

    // ----------------------------------------
    // pattern timer
    // ----------------------------------------
    // restart on a mode change so the first edge lands where the bench plans
    always_ff @(posedge clk)
    begin
        mode_ff <= mode;
        if (srst || mode != mode_ff || !rst_n)
            cnt_ff <= 11'h000;
        else if (cnt_ff != 11'h4AF)
            cnt_ff <= cnt_ff + 11'h001;
        else if (mode == 2'h2)
            cnt_ff <= 11'h000;
    end

    // idle level is the pull-up; a 1200 cycle period spans six samples
    always_comb
    begin
        case (mode)
            2'h0: wd_trig = 1'b1;
            2'h1: wd_trig = 1'b0;
            2'h2: wd_trig = cnt_ff < 11'h258;
            default: wd_trig = rst_n && cnt_ff >= 11'h014;
        endcase
    end
endmodule : ssw_mcu_model

// [dv/test_ssw_top.sv]
// self-checking bench for the supervisor and window watchdog
`timescale 1ns/10ps
module test_ssw_top;
    import ssw_pkg::*;

    logic clk = 1'b0;
    logic srst = 1'b1;
    logic ign = 1'b0;
    logic ctl = 1'b0;
    logic stop = 1'b0;
    logic [1:0] mode = 2'h0;
    ssw_status_type st = '{battery_ok: 1'b1, default: 1'b0};
    ssw_supply_en_type en;
    logic trig, rst1_wire, rst2_wire, drv1, oe1, drv2, oe2;
    logic mon, fault, active;
    int errors = 0;
    int tests_run = 0;

    // ----------------------------------------
    // clock, open drain lines, instances
    // ----------------------------------------
    always #2.5 clk = ~clk;
    // both reset lines carry a pull-up
    assign rst1_wire = oe1 ? drv1 : 1'b1;
    assign rst2_wire = oe2 ? drv2 : 1'b1;

    ssw_top #(.TICK_CYCLES(20)) uut (
        .REF_CLK(clk), .SRST(srst), .IGNITION_ENABLE_IN(ign),
        .CONTROLLER_ENABLE_IN(ctl), .RAIL_STATUS(st),
        .TIMEBASE_STOP(stop), .WD_TRIGGER_IN(trig),
        .RESET_OUT_PRIMARY_IN(rst1_wire),
        .RESET_OUT_SECONDARY_IN(rst2_wire), .SUPPLY_EN(en),
        .RESET_OUT_PRIMARY_DRV(drv1), .RESET_OUT_PRIMARY_OE(oe1),
        .RESET_OUT_SECONDARY_DRV(drv2), .RESET_OUT_SECONDARY_OE(oe2),
        .STANDBY_MONITOR_OUT(mon), .WD_FAULT_OUT(fault),
        .WD_ACTIVE(active));

    ssw_mcu_model mcu (.clk(clk), .srst(srst), .mode(mode),
        .rst_n(rst2_wire), .wd_trig(trig));

    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task at(input int n);
        repeat (n) @(posedge clk);
    endtask : at

    // sample 2 ns after the edge so register updates have landed
    task snap(input int n);
        repeat (n) @(posedge clk);
        #2;
    endtask : snap

    task chk(input logic got, input logic exp, input string what);
        tests_run++;
        if (got !== exp)
        begin
            errors++;
            $display("[ERR] %0t %s", $time, what);
        end
    endtask : chk

    // bounded wait on the secondary reset enable (0) or fault output (1)
    task wait_for(input logic v, input int sel, input int bound);
        int i;
        for (i = 0; i < bound; i++)
        begin
            snap(1);
            if ((sel == 0 ? oe2 : fault) === v)
                break;
        end
        chk((sel == 0 ? oe2 : fault), v, "wait bound ran out");
        if (i == bound)
            results();
    endtask : wait_for

    task results;
        $display("tests %0d errors %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : results

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial
    begin
        int i;
        logic ok;
        at(4);
        srst <= 1'b0;
        at(1);
        ign <= 1'b1;
        // battery_ok needs the two synchroniser stages after release
        snap(3); chk(en.regulators, 1'b1, "ign on");
        at(1);
        ign <= 1'b0;
        ctl <= 1'b1;
        snap(1); chk(en.trackers, 1'b1, "ctl on");
        at(1);
        ctl <= 1'b0;
        snap(1); chk(en.charge_pump, 1'b0, "pump off");
        chk(en.regulators, 1'b0, "reg off");
        chk(en.standby, 1'b1, "standby");
        at(1);
        ign <= 1'b1;
        st.ot_shutdown <= 1'b1;
        snap(4); chk(en.buck, 1'b0, "hot");
        chk(en.regulators, 1'b1, "hot reg");
        at(1);
        st.ot_shutdown <= 1'b0;
        snap(4); chk(en.buck, 1'b0, "hysteresis");
        at(1);
        st.ot_cooled <= 1'b1;
        snap(4); chk(en.buck, 1'b1, "cooled");
        // battery below range removes every enable, stand-by included
        at(1);
        st.battery_ok <= 1'b0;
        snap(4); chk(en.regulators, 1'b0, "battery low");
        chk(en.standby, 1'b0, "stby battery");
        $display("test enables done");
        // release delay: 160 ticks of 20 cycles after the rails settle
        at(1);
        st.battery_ok <= 1'b1;
        st.ot_cooled <= 1'b0;
        st.rail_5v_ok <= 1'b1;
        st.rail_mid_ok <= 1'b1;
        st.ext_fb_ok <= 1'b1;
        snap(3140); chk(oe1, 1'b1, "rst1 early");
        chk(oe2, 1'b1, "rst2 early");
        snap(100); chk(oe1, 1'b0, "rst1 late");
        chk(oe2, 1'b0, "rst2 late");
        chk(drv1 | drv2, 1'b0, "drive value");
        at(1);
        st.ext_fb_ok <= 1'b0;
        snap(5); chk(oe2, 1'b1, "fb bad");
        chk(oe1, 1'b0, "rst1 kept");
        at(1);
        st.ext_fb_ok <= 1'b1;
        st.rail_5v_ok <= 1'b0;
        snap(5); chk(oe1, 1'b1, "5v bad");
        $display("test resets done");
        at(1);
        st.standby_uv <= 1'b1;
        snap(4); chk(mon, 1'b0, "uv in reset");
        at(1);
        st.standby_uv <= 1'b0;
        snap(4); chk(mon, 1'b0, "uv held");
        at(1);
        st.rail_5v_ok <= 1'b1;
        snap(3240); chk(oe1, 1'b0, "rst1 up");
        chk(mon, 1'b0, "mon delay");
        chk(active, 1'b0, "no start");
        snap(200); chk(mon, 1'b1, "mon up");
        at(1);
        st.standby_uv <= 1'b1;
        snap(4); chk(mon, 1'b0, "power fail");
        at(1);
        st.standby_uv <= 1'b0;
        snap(4); chk(mon, 1'b1, "power back");
        $display("test monitor done");
        // start: trigger low through the hold, released inside ignore
        at(1);
        mode <= 2'h1;
        st.rail_mid_ok <= 1'b0;
        at(5);
        st.rail_mid_ok <= 1'b1;
        wait_for(1'b0, 0, 4000);
        at(700);
        mode <= 2'h2;
        snap(100); chk(active, 1'b1, "started");
        ok = 1'b1;
        for (i = 0; i < 7200; i++)
        begin
            snap(1);
            ok = ok & fault;
        end
        chk(ok, 1'b1, "good kicks");
        at(1);
        mode <= 2'h0;
        wait_for(1'b0, 1, 1500);
        snap(600); chk(fault, 1'b0, "fault held");
        at(1);
        mode <= 2'h2;
        wait_for(1'b1, 1, 5000);
        at(1);
        stop <= 1'b1;
        wait_for(1'b0, 1, 3000);
        $display("test watchdog done");
        at(1);
        stop <= 1'b0;
        mode <= 2'h3;
        st.rail_mid_ok <= 1'b0;
        snap(5); chk(active, 1'b0, "rst2 stops");
        at(1);
        st.rail_mid_ok <= 1'b1;
        wait_for(1'b0, 0, 4000);
        snap(1500); chk(active, 1'b0, "early high");
        $display("test restart done");
        results();
    end
endmodule : test_ssw_top
